// ### hw/bss_pkg.sv
package bss_pkg;
  // Timing figures
  localparam int CLK_PERIOD_NS   = 4;     // System clock period
  localparam int BLANK_NS        = 160;   // Overcurrent blanking after LS on
  localparam int BLANK_CYC       = (BLANK_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int MIN_ON_NS       = 50;    // Least high-side on time
  localparam int MIN_ON_CYC      = (MIN_ON_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int MAX_OFF_NS      = 200;   // Forced off time per period
  localparam int MAX_OFF_CYC     = MAX_OFF_NS / CLK_PERIOD_NS;
  // Switching-cycle counts
  localparam int HICCUP_CYCLES   = 4096;  // Hiccup hold length
  localparam int PG_DELAY_CYCLES = 256;   // Regulation-good qualification
  localparam int STEP1_PULSES    = 32;    // Quarter duty group
  localparam int STEP2_PULSES    = 16;    // Half duty group
  localparam int STEP3_PULSES    = 8;     // Three-quarter duty group

  // Sequencer states
  typedef enum logic [2:0] {
    BSS_OFF,
    BSS_WAIT_HS,
    BSS_PREBIAS,
    BSS_RUN,
    BSS_HICCUP,
    BSS_THERMAL
  } bss_state_t;

  // Comparator results from the analog front end
  typedef struct packed {
    logic supply_ok;      // Bias supply above lockout
    logic enable_ok;      // Enable above start threshold
    logic enable_low;     // Enable below 1 V shutdown level
    logic ss_forced_low;  // Soft-start node below 0.3 V
    logic ss_above_pg;    // Soft-start node above 2.1 V
    logic fb_above_low;   // Feedback above lower window limit
    logic fb_below_high;  // Feedback below upper window limit
    logic ocp_below_gnd;  // Current-limit node below ground
    logic over_temp;      // Thermal trip, hysteresis in comparator
    logic track_above;    // Tracking input above 0.85 V
  } bss_sense_t;

  // Driver commands to the power stage
  typedef struct packed {
    logic hs_en;          // High-side switch enable
    logic ls_en;          // Low-side switch enable
    logic drv_hiz_n;      // Low while both drivers are tristated
    logic ss_discharge;   // Short the soft-start node low
    logic use_int_ref;    // Internal reference drives regulation
  } bss_drive_t;
endpackage

// ### hw/bss_seq.sv
`timescale 1ns/100ps
module bss_seq
  import bss_pkg::*;
#(
  parameter int HICCUP_LEN = HICCUP_CYCLES,    // Hiccup length, cycles
  parameter int PG_DELAY   = PG_DELAY_CYCLES,  // Good delay, cycles
  parameter int CNT_W      = 13                // Counter width
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       period_start,
  input  wire logic       pwm_demand,
  input  wire logic [1:0] ls_phase,
  input  wire bss_sense_t sense,
  output bss_drive_t      drive,
  output logic            ocp_latched,
  output logic            regulation_good_out_o,
  output logic            regulation_good_out_oe_n,
  output bss_state_t      state
);

  bss_state_t       state_ff;        // Sequencer state
  bss_state_t       nxt_state;       // Next sequencer state
  logic [CNT_W-1:0] hic_cnt_ff;      // Hiccup period counter
  logic [8:0]       pg_cnt_ff;       // Regulation-good delay counter
  logic [5:0]       step_cnt_ff;     // Pulses left in duty step
  logic [1:0]       step_ff;         // Duty step, 0 quarter .. 3 full
  logic [7:0]       blank_cnt_ff;    // Overcurrent blanking counter
  logic [7:0]       on_cnt_ff;       // High-side on-time counter
  logic [7:0]       off_cnt_ff;      // Forced off-time counter
  logic             hs_ff;           // High-side gate command
  logic             ls_ff;           // Low-side gate command
  logic             ocp_ff;          // Latched overcurrent
  logic             good_ff;         // Regulation good, released
  logic             lockout;         // Supply or enable invalid
  logic             in_window;       // Feedback inside window
  logic             shutdown;        // Any shutdown condition
  logic             switching;       // States that drive the stage
  logic             ls_allowed;      // Low-side duty gate
  logic             ocp_sample;      // Sampled overcurrent event

  // Pulses in a duty step group
  function automatic logic [5:0] step_len(input logic [1:0] s);
    case (s)
      2'h0:    step_len = 6'(STEP1_PULSES);
      2'h1:    step_len = 6'(STEP2_PULSES);
      default: step_len = 6'(STEP3_PULSES);
    endcase
  endfunction

  // Lockout and window decode
  // Enable below shutdown level counts as lockout
  assign lockout   = !(sense.supply_ok && sense.enable_ok)
                     || sense.enable_low;
  assign in_window = sense.fb_above_low && sense.fb_below_high;
  assign shutdown  = lockout || sense.ss_forced_low
                     || state_ff == BSS_HICCUP
                     || state_ff == BSS_THERMAL;
  // States that may command the power stage
  assign switching = state_ff == BSS_WAIT_HS || state_ff == BSS_PREBIAS
                     || state_ff == BSS_RUN;
  // Overcurrent sampled only after blanking, with the low side on in pre-bias or run
  // Blanking hides ringing after low-side turn-on
  assign ocp_sample = switching && ls_ff && blank_cnt_ff == 8'h00
                      && sense.ocp_below_gnd;

  // Low-side duty: phase 0..3 quarter slots of each period
  // Early quarters only, to spare a pre-charged output
  always_comb begin
    ls_allowed = 1'b1;
    if (state_ff == BSS_WAIT_HS) begin
      ls_allowed = 1'b0;
    end else if (state_ff == BSS_PREBIAS) begin
      ls_allowed = ls_phase <= step_ff;
    end
  end

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      // Start once every start condition holds
      BSS_OFF: begin
        if (!lockout && !sense.ss_forced_low && !sense.over_temp) begin
          nxt_state = BSS_WAIT_HS;
        end
      end
      // Low side held until the first high-side pulse
      BSS_WAIT_HS: begin
        if (hs_ff) begin
          nxt_state = BSS_PREBIAS;
        end
      end
      // Full duty reached, next tick enters run
      BSS_PREBIAS: begin
        if (period_start && step_ff == 2'h3) begin
          nxt_state = BSS_RUN;
        end
      end
      // Steady switching until a fault
      BSS_RUN:     nxt_state = BSS_RUN;
      // Latch cleared by the hold count, restart
      BSS_HICCUP: begin
        if (!ocp_ff) begin
          nxt_state = BSS_OFF;
        end
      end
      // Cool again, restart on its own
      BSS_THERMAL: begin
        if (!sense.over_temp) begin
          nxt_state = BSS_OFF;
        end
      end
      // Unused codes fall back to off
      default:     nxt_state = BSS_OFF;
    endcase
    // Fault priority over the sequence
    // Lockout and forced soft start, then heat, then current
    if (lockout || sense.ss_forced_low) begin
      nxt_state = BSS_OFF;
    end else if (sense.over_temp) begin
      nxt_state = BSS_THERMAL;
    end else if (ocp_sample || (ocp_ff && state_ff != BSS_HICCUP)) begin
      nxt_state = BSS_HICCUP;
    end
  end

  // State register
  // Frozen while the clock enable is low
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= BSS_OFF;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // Overcurrent latch, set wins over the hiccup clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ocp_ff <= 1'b0;
    end else if (clk_en) begin
      if (ocp_sample) begin
        ocp_ff <= 1'b1;
      end else if (state_ff == BSS_HICCUP && period_start
                   && hic_cnt_ff == CNT_W'(HICCUP_LEN - 1)) begin
        ocp_ff <= 1'b0;
      end else if (lockout) begin
        // Clean latch for the next start
        ocp_ff <= 1'b0;
      end
    end
  end

  // Hiccup counter, one step per switching period
  // Counts only while the soft-start node is held
  always_ff @(posedge clk) begin
    if (rst) begin
      hic_cnt_ff <= '0;
    end else if (clk_en) begin
      if (state_ff != BSS_HICCUP) begin
        hic_cnt_ff <= '0;
      end else if (period_start) begin
        hic_cnt_ff <= hic_cnt_ff + 1'b1;
      end
    end
  end

  // Pre-bias duty step sequencing
  // Full duty needs no count of its own
  always_ff @(posedge clk) begin
    if (rst) begin
      step_ff     <= 2'h0;
      step_cnt_ff <= 6'h00;
    end else if (clk_en) begin
      if (state_ff != BSS_PREBIAS) begin
        step_ff     <= 2'h0;
        step_cnt_ff <= step_len(2'h0);
      end else if (period_start && step_ff != 2'h3) begin
        if (step_cnt_ff == 6'h01) begin
          step_ff     <= step_ff + 2'h1;
          step_cnt_ff <= step_len(step_ff + 2'h1);
        end else begin
          step_cnt_ff <= step_cnt_ff - 6'h01;
        end
      end
    end
  end

  // High-side gate with least on time and forced off time
  // Leaving for a quiet state drops the gate at once
  // New pulses start only at a period tick
  always_ff @(posedge clk) begin
    if (rst) begin
      hs_ff     <= 1'b0;
      on_cnt_ff <= 8'h00;
      off_cnt_ff <= 8'h00;
    end else if (clk_en) begin
      if (!switching || nxt_state != state_ff
          && nxt_state != BSS_PREBIAS && nxt_state != BSS_RUN) begin
        hs_ff <= 1'b0;
        on_cnt_ff <= 8'h00;
      end else if (hs_ff) begin
        // Pulse running, count its on time
        on_cnt_ff <= on_cnt_ff + 8'h01;
        if (on_cnt_ff >= 8'(MIN_ON_CYC - 1) && !pwm_demand) begin
          hs_ff      <= 1'b0;
          off_cnt_ff <= 8'(MAX_OFF_CYC);
        end
      end else if (off_cnt_ff != 8'h00) begin
        // Forced off time still running
        off_cnt_ff <= off_cnt_ff - 8'h01;
      end else if (pwm_demand && period_start) begin
        hs_ff     <= 1'b1;
        on_cnt_ff <= 8'h00;
      end
    end
  end

  // Low-side gate and blanking after it turns on
  // Any fault or closed quarter rearms blanking
  always_ff @(posedge clk) begin
    if (rst) begin
      ls_ff        <= 1'b0;
      blank_cnt_ff <= 8'h00;
    end else if (clk_en) begin
      if (!switching || hs_ff || !ls_allowed || lockout
          || sense.over_temp || sense.ss_forced_low) begin
        ls_ff        <= 1'b0;
        blank_cnt_ff <= 8'(BLANK_CYC);
      end else begin
        // Low side closed, blanking runs down
        ls_ff <= 1'b1;
        if (blank_cnt_ff != 8'h00) begin
          blank_cnt_ff <= blank_cnt_ff - 8'h01;
        end
      end
    end
  end

  // Regulation-good qualification delay
  // Tracking start skips the soft-start level hold
  always_ff @(posedge clk) begin
    if (rst) begin
      pg_cnt_ff <= 9'h000;
      good_ff   <= 1'b0;
    end else if (clk_en) begin
      // Fault entry clears in the same edge, no lag
      if (shutdown || !in_window
          || nxt_state == BSS_HICCUP || nxt_state == BSS_THERMAL
          || (!sense.track_above && !sense.ss_above_pg)) begin
        pg_cnt_ff <= 9'h000;
        good_ff   <= 1'b0;
      end else if (pg_cnt_ff == 9'(PG_DELAY)) begin
        // Delay ran out, release the pin
        good_ff <= 1'b1;
      end else if (period_start) begin
        pg_cnt_ff <= pg_cnt_ff + 9'h001;
      end
    end
  end

  // Outputs to the power stage and pins
  // Tristate follows the enable comparator directly
  always_comb begin
    drive.hs_en        = hs_ff;
    drive.ls_en        = ls_ff;
    drive.drv_hiz_n    = !sense.enable_low;
    drive.ss_discharge = state_ff == BSS_HICCUP
                         || state_ff == BSS_THERMAL;
    drive.use_int_ref  = sense.track_above;
  end
  assign ocp_latched = ocp_ff;
  // Open drain: drive low unless good, pull-up lifts it
  assign regulation_good_out_o    = 1'b0;
  assign regulation_good_out_oe_n = good_ff;
  assign state = state_ff;

endmodule // bss_seq

// ### verif/bss_seq_props.sv
`timescale 1ns/100ps
// Port checks of the sequencer
module bss_seq_props
  import bss_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire bss_sense_t sense,
  input wire bss_drive_t drive,
  input wire logic       ocp_latched,
  input wire logic       regulation_good_out_oe_n,
  input wire bss_state_t state
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_lockout_off: assert property (
    !(sense.supply_ok && sense.enable_ok) |=> !(drive.hs_en || drive.ls_en))
    else $error("driver on in lockout");
  a_enable_hiz: assert property (
    drive.drv_hiz_n == !sense.enable_low) else $error("hiz wrong");
  a_ocp_hiccup: assert property (
    $rose(ocp_latched) |-> state == BSS_HICCUP && drive.ss_discharge)
    else $error("no hiccup on overcurrent");
  a_ocp_needs_ls: assert property (
    $rose(ocp_latched) |-> $past(drive.ls_en) && $past(sense.ocp_below_gnd))
    else $error("overcurrent taken with low side off");
  a_hiccup_hold: assert property (
    state == BSS_HICCUP |-> drive.ss_discharge && !drive.hs_en)
    else $error("hiccup not holding");
  a_ls_waits_hs: assert property (
    state == BSS_WAIT_HS |-> !drive.ls_en) else $error("low side early");
  a_good_qual: assert property (
    $rose(regulation_good_out_oe_n) |-> $past(sense.fb_above_low &&
    sense.fb_below_high && (sense.ss_above_pg || sense.track_above)))
    else $error("good released unqualified");
  a_good_window: assert property (
    regulation_good_out_oe_n && !sense.fb_below_high |=>
    !regulation_good_out_oe_n) else $error("good kept outside window");
  a_min_on: assert property (
    $fell(drive.hs_en) && $stable(state) |-> $past(drive.hs_en, MIN_ON_CYC))
    else $error("high-side pulse too short");
  a_good_fault: assert property (
    state == BSS_HICCUP || state == BSS_THERMAL |-> !regulation_good_out_oe_n)
    else $error("good released during fault");
  c_hiccup: cover property ($rose(ocp_latched));
  c_good: cover property ($rose(regulation_good_out_oe_n));
  c_run: cover property (state == BSS_PREBIAS ##1 state == BSS_RUN);
endmodule // bss_seq_props

bind bss_seq bss_seq_props u_props (.clk(clk), .rst(rst), .sense(sense),
  .drive(drive), .ocp_latched(ocp_latched), .state(state),
  .regulation_good_out_oe_n(regulation_good_out_oe_n));

// ### verif/bss_seq_test.sv
`timescale 1ns/100ps
// Bench for the start-up and protection sequencer
module bss_seq_test;
  import bss_pkg::*;
  localparam int HL = 8;           // Short hiccup
  localparam int PD = 4;           // Short good delay
  logic       clk = 1'b0;          // 250 MHz clock
  logic       rst = 1'b1;          // Reset, held four clocks
  logic       ps, pwm, overcurrent_trip, pg, oe_n, pg_o;     // Stage and flag nets
  logic [1:0] ph, pv_ph = 2'h0, pv_stp = 2'h0;  // Quarter, last, step
  logic       pv_pre = 1'b0;       // Last cycle was pre-bias
  bss_sense_t sn = 10'h318;        // All valid, in window, no faults
  bss_drive_t drv;                 // Driver commands
  bss_state_t st;                  // Sequencer state
  int         mismatches = 0;      // Failed comparisons
  int         n_tests = 0;         // All comparisons
  int         cyc = 0, pc = 0, pre = 0, i, n;   // Counters
  always #2 clk = ~clk;
  bss_seq #(.HICCUP_LEN(HL), .PG_DELAY(PD)) dut (.clk(clk), .rst(rst),
    .clk_en(1'b1), .period_start(ps), .pwm_demand(pwm), .ls_phase(ph),
    .sense(sn), .drive(drv), .ocp_latched(overcurrent_trip), .state(st),
    .regulation_good_out_o(pg_o), .regulation_good_out_oe_n(oe_n));
  bss_stage_model u_stage (.clk(clk), .rst(rst), .pg_oe_n(oe_n),
    .pg_o(pg_o), .period_start(ps), .pwm_demand(pwm), .ls_phase(ph),
    .pg_pin(pg));
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Tick counts, pre-bias duty watch and hang limit
  always @(posedge clk) begin
    cyc++;
    if (ps) pc++;
    if (st === BSS_OFF) pre = 0;
    if (st === BSS_PREBIAS && ps) pre++;
    if (pv_pre && drv.ls_en === 1'b1 && pv_ph > pv_stp)
      chk("ls_duty", pv_stp, pv_ph);
    pv_pre = (st === BSS_PREBIAS);
    pv_ph = ph;
    pv_stp = pre < STEP1_PULSES ? 2'h0
           : pre < STEP1_PULSES + STEP2_PULSES ? 2'h1
           : pre < STEP1_PULSES + STEP2_PULSES + STEP3_PULSES ? 2'h2 : 2'h3;
    if (cyc == 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    n = $urandom(32'hbb4939e1);
    tick(4);
    chk("rst_st", BSS_OFF, st);
    chk("rst_out", 0, {overcurrent_trip, pg, drv.hs_en, drv.ls_en});
    rst = 1'b0;
    for (i = 0; i < 12; i++) begin
      {sn.supply_ok, sn.enable_ok} = 2'(i % 3);
      sn.enable_low = 1'($urandom);
      sn.track_above = 1'($urandom);
      tick(3);
      chk("lock_st", BSS_OFF, st);
      chk("lock_drv", 0, {drv.hs_en, drv.ls_en, pg});
      chk("hiz", !sn.enable_low, drv.drv_hiz_n);
      chk("ref", sn.track_above, drv.use_int_ref);
    end
    sn = 10'h318;
    for (i = 0; i < 400 && drv.hs_en !== 1'b1; i++) begin
      chk("ls_early", 0, drv.ls_en);
      tick(1);
    end
    chk("hs_on", 1, drv.hs_en);
    for (i = 0; i < 9000 && st !== BSS_RUN; i++) tick(1);
    // One more tick closes the full-duty step
    chk("pre_n", STEP1_PULSES + STEP2_PULSES + STEP3_PULSES + 1, pre);
    tick(600);
    chk("pg_hold", 0, pg);
    sn.ss_above_pg = 1'b1;
    n = pc;
    for (i = 0; i < 3000 && pg !== 1'b1; i++) tick(1);
    chk("pg_dly", PD, pc - n);
    sn.fb_below_high = 1'b0;
    tick(2);
    chk("pg_win", 0, pg);
    sn.fb_below_high = 1'b1;
    for (i = 0; i < 200 && drv.hs_en !== 1'b1; i++) tick(1);
    sn.ocp_below_gnd = 1'b1;
    tick(1);
    sn.ocp_below_gnd = 1'b0;
    chk("ocp_ign", 0, overcurrent_trip);
    for (i = 0; i < 200 && drv.ls_en !== 1'b1; i++) tick(1);
    tick(45);
    sn.ocp_below_gnd = 1'b1;
    tick(1);
    sn.ocp_below_gnd = 1'b0;
    n = pc;
    chk("hic", {3'h6, 3'(BSS_HICCUP)}, {overcurrent_trip, drv.ss_discharge, pg, st});
    for (i = 0; i < 3000 && overcurrent_trip === 1'b1; i++) tick(1);
    chk("hic_len", HL, pc - n);
    sn.ocp_below_gnd = 1'b1;
    for (i = 0; i < 12000 && overcurrent_trip !== 1'b1; i++) tick(1);
    chk("hic_rpt", 1, overcurrent_trip);
    sn.ocp_below_gnd = 1'b0;
    for (i = 0; i < 3000 && overcurrent_trip === 1'b1; i++) tick(1);
    sn.over_temp = 1'b1;
    tick(2);
    chk("ot", {3'(BSS_THERMAL), 3'h4},
        {st, drv.ss_discharge, drv.hs_en, drv.ls_en});
    sn.over_temp = 1'b0;
    tick(3);
    chk("ot_end", 1, st !== BSS_THERMAL);
    for (i = 0; i < 400 && drv.hs_en !== 1'b1; i++) tick(1);
    sn.ss_forced_low = 1'b1;
    tick(2);
    chk("ss_low", {3'(BSS_OFF), 1'b0}, {st, pg});
    sn.ss_forced_low = 1'b0;
    tick(2);
    chk("ss_rel", 1, st !== BSS_OFF);
    print_verdict();
  end
endmodule // bss_seq_test

// ### verif/bss_stage_model.sv
`timescale 1ns/100ps
// Oscillator, PWM comparator and pull-up around the sequencer
module bss_stage_model (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  pg_oe_n,
  input  wire logic  pg_o,
  output logic       period_start,
  output logic       pwm_demand,
  output logic [1:0] ls_phase,
  output logic       pg_pin
);
  logic [6:0] cnt_ff;  // Clock within a 96-clock period
  // Free-running switching oscillator
  always_ff @(posedge clk) begin
    if (rst || cnt_ff == 7'h5f) begin
      cnt_ff <= 7'h00;
    end else begin
      cnt_ff <= cnt_ff + 7'h01;
    end
  end
  assign period_start = (cnt_ff == 7'h00);     // Tick per period
  assign ls_phase     = 2'(cnt_ff / 7'h18);    // Quarter of period
  assign pwm_demand   = (cnt_ff < 7'h1e);      // 120 ns on, 264 off
  assign pg_pin       = pg_oe_n ? 1'b1 : pg_o; // Pull-up when released
endmodule // bss_stage_model
